/* common/asr_consts.vh */
// Constants for the ASCII string receiver
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
`define ASR_ADDR_W       12
`define ASR_OFF_CTRL     12'h000
`define ASR_OFF_LEN      12'h004
`define ASR_OFF_TERM     12'h008
`define ASR_OFF_ICTO     12'h00C
`define ASR_OFF_FCTO     12'h010
`define ASR_OFF_DEST     12'h014
`define ASR_OFF_STAT     12'h018
`define ASR_OFF_COUNT    12'h01C
`define ASR_CTRL_EN      0
`define ASR_CTRL_VAR     1
`define ASR_CTRL_SWAP    2
`define ASR_CTRL_TERM2   3
`define ASR_ST_BUSY      0
`define ASR_ST_DONE      1
`define ASR_ST_ICTO      2
`define ASR_ST_FCTO      3
`define ASR_ST_OVF       4
`define ASR_ST_INVAL     5
`define ASR_ST_NOEXEC    6
`define ASR_ST_PBUSY     7
`define ASR_ST_PERR      8
`define ASR_LEN_MIN      8'h01
`define ASR_LEN_MAX      8'h80
`define ASR_TO_NONE      16'h0000
`define ASR_CLK_NS       40
`define ASR_MS_NS        1000000
`define ASR_MS_CYCLES    (`ASR_MS_NS / `ASR_CLK_NS)
`define ASR_RST_LEN      8'h01
`endif

/* rtl/asr_receiver.v */
// ASCII string receiver with APB register access and word memory write port
//
// Overview of operation
// - Fixed-count or terminator-ended framing, selectable
// - Store characters at consecutive words from base
// - Fixed length must be 1 to 128
// - Fixed mode completes after exactly length bytes
// - Inter-character gap timeout flags error, stores nothing
// - First character late flags first-character timeout
// - Timeout flags hold until enable drops
// - Zero timeout setting disables that check
// - Byte swap exchanges bytes in every word
// - Busy high while accepting characters
// - Variable maximum length must be 1 to 128
// - One or two character terminator ends string
// - Overflow when bytes exceed maximum before terminator
// - Variable complete on terminator, clears with enable
// - Port busy flag while port exchanges characters
// - Port error flag on serial communication error
// - Invalid flag on out-of-range configuration
// - Cannot-execute flag when operation cannot run
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "asr_consts.vh"
module asr_receiver #(
    parameter        MS_CYCLES = `ASR_MS_CYCLES,
    parameter        WORDS     = 65
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ser_valid,
    input  wire [7:0]  ser_data,
    input  wire        ser_active,
    input  wire        ser_err,
    output reg         mem_we,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata
);

    localparam [4:0] S_IDLE  = 5'h01;
    localparam [4:0] S_RECV  = 5'h02;
    localparam [4:0] S_DRAIN = 5'h04;
    localparam [4:0] S_DONE  = 5'h08;
    localparam [4:0] S_FAIL  = 5'h10;

    reg  [3:0]  ctrl_ff;
    reg  [7:0]  len_ff;
    reg  [15:0] term_ff;
    reg  [15:0] icto_ff;
    reg  [15:0] fcto_ff;
    reg  [15:0] dest_ff;
    reg  [4:0]  state_ff;
    reg  [4:0]  nxt_state;
    reg  [7:0]  cnt_ff;
    reg  [7:0]  nxt_cnt;
    reg  [7:0]  wptr_ff;
    reg  [7:0]  nxt_wptr;
    reg         en_d_ff;
    reg         busy_ff;
    reg         done_ff;
    reg         icto_err_ff;
    reg         fcto_err_ff;
    reg         ovf_ff;
    reg         inval_ff;
    reg         noexec_ff;
    reg         pbusy_ff;
    reg         perr_ff;
    reg  [31:0] pre_ff;
    reg  [15:0] ms_ff;
    reg  [7:0]  last_ff;
    reg  [15:0] buf_ff [0:WORDS-1];
    reg         set_icto;
    reg         set_fcto;
    reg         set_ovf;
    reg         set_inval;
    reg         set_noexec;
    reg         wr_byte;
    reg         nxt_mem_we;
    reg  [15:0] nxt_mem_addr;
    reg  [15:0] nxt_mem_wdata;
    reg  [15:0] word;
    reg  [31:0] rd_val;
    reg         rd_ok;

    wire        en        = ctrl_ff[`ASR_CTRL_EN];
    wire        var_mode  = ctrl_ff[`ASR_CTRL_VAR];
    wire        swap      = ctrl_ff[`ASR_CTRL_SWAP];
    wire        term_two  = ctrl_ff[`ASR_CTRL_TERM2];
    wire        start     = en & ~en_d_ff;
    wire        tick      = (pre_ff == MS_CYCLES - 1);
    wire        apb_setup = psel & penable & ~pready;
    wire        apb_acc   = psel & penable & pready;
    wire        len_bad   = (len_ff < `ASR_LEN_MIN) | (len_ff > `ASR_LEN_MAX);
    wire        hit_t0    = (ser_data == term_ff[7:0]);
    wire        hit_t1    = (ser_data == term_ff[15:8]);
    wire        pend_t0   = (cnt_ff != 8'h00) & (last_ff == term_ff[7:0]);
    wire        term_done = term_two ? (pend_t0 & hit_t1) : hit_t0;
    wire [7:0]  nwords    = (cnt_ff + 8'h01) >> 1;

    ////////////////////////////////////////////////////////////////////////////
    // Receive sequencer
    always @* begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_wptr   = wptr_ff;
        set_icto   = 1'b0;
        set_fcto   = 1'b0;
        set_ovf    = 1'b0;
        set_inval  = 1'b0;
        set_noexec = 1'b0;
        wr_byte    = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (start) begin
                    nxt_cnt  = 8'h00;
                    nxt_wptr = 8'h00;
                    if (len_bad) begin
                        set_inval = 1'b1;
                        nxt_state = S_FAIL;
                    end else if (ser_err) begin
                        set_noexec = 1'b1;
                        nxt_state  = S_FAIL;
                    end else begin
                        nxt_state = S_RECV;
                    end
                end
            end
            S_RECV: begin
                if (ser_valid) begin
                    if (!var_mode) begin
                        wr_byte = 1'b1;
                        nxt_cnt = cnt_ff + 8'h01;
                        if (cnt_ff + 8'h01 == len_ff) begin
                            nxt_state = S_DRAIN;
                        end
                    end else if (term_done) begin
                        if (term_two) begin
                            nxt_cnt = cnt_ff - 8'h01;
                        end
                        nxt_state = S_DRAIN;
                    end else if ((cnt_ff > len_ff) ||
                                 ((cnt_ff == len_ff) && !(term_two && hit_t0))) begin
                        set_ovf   = 1'b1;
                        nxt_state = S_FAIL;
                    end else begin
                        wr_byte = 1'b1;
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                end else if (tick) begin
                    if (cnt_ff == 8'h00) begin
                        if (fcto_ff != `ASR_TO_NONE && ms_ff + 16'h0001 > fcto_ff) begin
                            set_fcto  = 1'b1;
                            nxt_state = S_FAIL;
                        end
                    end else if (icto_ff != `ASR_TO_NONE &&
                                 ms_ff + 16'h0001 > icto_ff) begin
                        set_icto  = 1'b1;
                        nxt_state = S_FAIL;
                    end
                end
            end
            S_DRAIN: begin
                if (wptr_ff + 8'h01 >= nwords) begin
                    nxt_state = S_DONE;
                end
                nxt_wptr = wptr_ff + 8'h01;
            end
            S_DONE: begin
                nxt_state = S_DONE;
            end
            S_FAIL: begin
                nxt_state = S_FAIL;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (!en) begin
            nxt_state = S_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word write-out from the staging buffer
    always @* begin
        word          = buf_ff[wptr_ff[6:0]];
        nxt_mem_we    = 1'b0;
        nxt_mem_addr  = mem_addr;
        nxt_mem_wdata = mem_wdata;
        if (state_ff == S_DRAIN && en && wptr_ff < nwords) begin
            if (wptr_ff + 8'h01 == nwords && cnt_ff[0]) begin
                word[15:8] = 8'h00;
            end
            nxt_mem_we    = 1'b1;
            nxt_mem_addr  = dest_ff + {8'h00, wptr_ff};
            nxt_mem_wdata = swap ? {word[7:0], word[15:8]} : word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux
    always @* begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (paddr == `ASR_OFF_CTRL) begin
            rd_val[3:0] = ctrl_ff;
        end else if (paddr == `ASR_OFF_LEN) begin
            rd_val[7:0] = len_ff;
        end else if (paddr == `ASR_OFF_TERM) begin
            rd_val[15:0] = term_ff;
        end else if (paddr == `ASR_OFF_ICTO) begin
            rd_val[15:0] = icto_ff;
        end else if (paddr == `ASR_OFF_FCTO) begin
            rd_val[15:0] = fcto_ff;
        end else if (paddr == `ASR_OFF_DEST) begin
            rd_val[15:0] = dest_ff;
        end else if (paddr == `ASR_OFF_STAT) begin
            rd_val[`ASR_ST_BUSY]   = busy_ff;
            rd_val[`ASR_ST_DONE]   = done_ff;
            rd_val[`ASR_ST_ICTO]   = icto_err_ff;
            rd_val[`ASR_ST_FCTO]   = fcto_err_ff;
            rd_val[`ASR_ST_OVF]    = ovf_ff;
            rd_val[`ASR_ST_INVAL]  = inval_ff;
            rd_val[`ASR_ST_NOEXEC] = noexec_ff;
            rd_val[`ASR_ST_PBUSY]  = pbusy_ff;
            rd_val[`ASR_ST_PERR]   = perr_ff;
        end else if (paddr == `ASR_OFF_COUNT) begin
            rd_val[7:0] = cnt_ff;
        end else begin
            rd_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, write lands on the pready edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ctrl_ff <= 4'h0;
            len_ff  <= `ASR_RST_LEN;
            term_ff <= 16'h0000;
            icto_ff <= `ASR_TO_NONE;
            fcto_ff <= `ASR_TO_NONE;
            dest_ff <= 16'h0000;
        end else if (clk_en) begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~rd_ok;
            if (apb_setup && !pwrite) begin
                prdata <= rd_val;
            end
            if (apb_acc && pwrite) begin
                if (paddr == `ASR_OFF_CTRL) begin
                    ctrl_ff <= pwdata[3:0];
                end else if (paddr == `ASR_OFF_LEN) begin
                    len_ff <= pwdata[7:0];
                end else if (paddr == `ASR_OFF_TERM) begin
                    term_ff <= pwdata[15:0];
                end else if (paddr == `ASR_OFF_ICTO) begin
                    icto_ff <= pwdata[15:0];
                end else if (paddr == `ASR_OFF_FCTO) begin
                    fcto_ff <= pwdata[15:0];
                end else if (paddr == `ASR_OFF_DEST) begin
                    dest_ff <= pwdata[15:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state, timers and flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= S_IDLE;
            cnt_ff      <= 8'h00;
            wptr_ff     <= 8'h00;
            en_d_ff     <= 1'b0;
            busy_ff     <= 1'b0;
            done_ff     <= 1'b0;
            icto_err_ff <= 1'b0;
            fcto_err_ff <= 1'b0;
            ovf_ff      <= 1'b0;
            inval_ff    <= 1'b0;
            noexec_ff   <= 1'b0;
            pbusy_ff    <= 1'b0;
            perr_ff     <= 1'b0;
            pre_ff      <= 32'h0000_0000;
            ms_ff       <= 16'h0000;
            last_ff     <= 8'h00;
            mem_we      <= 1'b0;
            mem_addr    <= 16'h0000;
            mem_wdata   <= 16'h0000;
        end else if (clk_en) begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            wptr_ff   <= nxt_wptr;
            en_d_ff   <= en;
            busy_ff   <= (nxt_state == S_RECV);
            pbusy_ff  <= ser_active;
            mem_we    <= nxt_mem_we;
            mem_addr  <= nxt_mem_addr;
            mem_wdata <= nxt_mem_wdata;
            if (ser_valid) begin
                last_ff <= ser_data;
            end
            if (start || ser_valid || state_ff != S_RECV) begin
                pre_ff <= 32'h0000_0000;
                ms_ff  <= 16'h0000;
            end else if (tick) begin
                pre_ff <= 32'h0000_0000;
                ms_ff  <= ms_ff + 16'h0001;
            end else begin
                pre_ff <= pre_ff + 32'h0000_0001;
            end
            if (!en) begin
                done_ff     <= 1'b0;
                icto_err_ff <= 1'b0;
                fcto_err_ff <= 1'b0;
                ovf_ff      <= 1'b0;
                inval_ff    <= 1'b0;
                noexec_ff   <= 1'b0;
            end else begin
                done_ff     <= done_ff | (nxt_state == S_DONE);
                icto_err_ff <= icto_err_ff | set_icto;
                fcto_err_ff <= fcto_err_ff | set_fcto;
                ovf_ff      <= ovf_ff | set_ovf;
                inval_ff    <= inval_ff | set_inval;
                noexec_ff   <= noexec_ff | set_noexec;
            end
            if (ser_err) begin
                perr_ff <= 1'b1;
            end else if (start) begin
                perr_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Staging buffer: nothing reaches memory until the string is whole
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_buf
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_ff[gi] <= 16'h0000;
                end else if (clk_en && wr_byte && cnt_ff[7:1] == gi) begin
                    if (cnt_ff[0]) begin
                        buf_ff[gi][15:8] <= ser_data;
                    end else begin
                        buf_ff[gi][7:0] <= ser_data;
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* testbench/asr_receiver_assertions.sv */
// Port-level checks for the ASCII string receiver
`timescale 1ns/1ns
`default_nettype none
module asr_receiver_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ser_valid,
    input wire logic [7:0]  ser_data,
    input wire logic        ser_active,
    input wire logic        ser_err,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata
);
    logic [15:0] base_ff;
    logic [6:0]  run_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Destination base as last written, and length of the current write burst
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= 16'h0;
            run_ff <= 7'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h014)
                base_ff <= pwdata[15:0];
            run_ff <= mem_we ? run_ff + 7'h1 : 7'h0;
        end
    end
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held two cycles");
    property p_rdy_wait; $rose(penable) && psel |=> pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready not after one wait");
    property p_rdy_acc; pready |-> psel && penable; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
    property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
    property p_base; $rose(mem_we) |-> mem_addr == base_ff; endproperty
    a_base: assert property (p_base) else $error("first word off base");
    property p_step; mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 16'h1; endproperty
    a_step: assert property (p_step) else $error("word address skipped");
    property p_run; run_ff <= 7'h40; endproperty
    a_run: assert property (p_run) else $error("more than 64 words");
    property p_drain; $rose(mem_we) |-> $past(ser_valid, 2); endproperty
    a_drain: assert property (p_drain) else $error("write-out not after end");
endmodule
bind asr_receiver asr_receiver_assertions chk_i (.*);
`default_nettype wire

/* testbench/asr_char_source.sv */
// Character source standing in for a scanner on the serial side
`timescale 1ns/1ns
`default_nettype none
module asr_char_source (
    input  wire logic       pclk,
    output var  logic       ser_valid,
    output var  logic [7:0] ser_data,
    output var  logic       ser_active,
    output var  logic       ser_err
);
    initial begin
        ser_valid = 1'b0;
        ser_data = 8'hA5;
        ser_active = 1'b0;
        ser_err = 1'b0;
    end
    // One-cycle strobe per character; the data line toggles while idle
    task send(input logic [7:0] q[$], input int gap);
        int i;
        for (i = 0; i < q.size(); i++) begin
            @(posedge pclk);
            ser_active <= 1'b1;
            ser_valid <= 1'b1;
            ser_data <= q[i];
            repeat (gap) @(posedge pclk) begin
                ser_valid <= 1'b0;
                ser_data <= ~ser_data;
            end
        end
        @(posedge pclk);
        ser_valid <= 1'b0;
        ser_data <= ~ser_data;
        ser_active <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/asr_receiver_tb.sv */
// Self-checking bench for the ASCII string receiver
`timescale 1ns/1ns
`default_nettype none
module asr_receiver_tb;
`include "asr_consts.vh"
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, clk_en = 1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, mem_we, ser_valid, ser_active, ser_err;
    wire  [7:0]  ser_data;
    wire  [15:0] mem_addr, mem_wdata;
    int          bad_count = 0, num_checks = 0, seed = 32'hc973, k, n;
    logic [15:0] d;
    logic [7:0]  bq[$], tq[$];
    logic [31:0] mq[$];
    int          lens[4] = '{1, 2, 128, 0};
    asr_receiver #(.MS_CYCLES(8)) dut (.*);
    asr_char_source src (.*);
    initial forever #20 pclk = ~pclk;
    always @(posedge pclk) if (mem_we === 1'b1) mq.push_back({mem_addr, mem_wdata});
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task st(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, `ASR_OFF_STAT, 32'h0);
        chk("stat", e, rd & m);
    endtask
    task go(input logic [3:0] c, input logic [7:0] l, input logic [15:0] t, i, f, b);
        apb(1'b1, `ASR_OFF_LEN, 32'(l));
        apb(1'b1, `ASR_OFF_TERM, 32'(t));
        apb(1'b1, `ASR_OFF_ICTO, 32'(i));
        apb(1'b1, `ASR_OFF_FCTO, 32'(f));
        apb(1'b1, `ASR_OFF_DEST, 32'(b));
        mq.delete();
        apb(1'b1, `ASR_OFF_CTRL, 32'(c));
    endtask
    task stop;
        apb(1'b1, `ASR_OFF_CTRL, 32'h0);
        st(32'h7F, 32'h0);
    endtask
    task wdone;
        int i;
        rd = 32'h0;
        for (i = 0; i < 300 && rd[1] !== 1'b1; i++) apb(1'b0, `ASR_OFF_STAT, 32'h0);
    endtask
    // Expected words from the byte model: pairs, first byte low, optional swap
    task cmem(input logic [15:0] b, input logic sw);
        int i;
        logic [7:0] lo, hi;
        chk("words", (bq.size() + 1) / 2, mq.size());
        for (i = 0; i < mq.size(); i++) begin
            lo = bq[2*i];
            hi = (2*i + 1 < bq.size()) ? bq[2*i+1] : 8'h00;
            chk("word", {b + 16'(i), sw ? {lo, hi} : {hi, lo}}, mq[i]);
        end
    endtask
    task end_of_test;
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        $display("Watchdog expired");
        end_of_test;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 8; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk("reset", 32'(k == 1), rd);
        end
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        chk("slverr", 32'h1, 32'(er));
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("Registers done");
        for (k = 0; k < 4; k++) begin
            n = lens[k] ? lens[k] : 3 + $unsigned($random(seed)) % 120;
            d = 16'($random(seed));
            bq.delete();
            repeat (n) bq.push_back(8'($random(seed)));
            go({1'b0, k[0], 1'b0, 1'b1}, 8'(n), 16'h0, 16'h0, 16'h0, d);
            src.send(bq, k);
            wdone;
            st(32'h7F, 32'h2);
            apb(1'b0, `ASR_OFF_COUNT, 32'h0);
            chk("count", 32'(n), rd);
            cmem(d, k[0]);
            stop;
        end
        $display("Fixed done");
        for (k = 0; k < 2; k++) begin
            n = 1 + $unsigned($random(seed)) % 40;
            d = 16'($random(seed));
            bq.delete();
            repeat (n) bq.push_back(8'h20 + 8'($unsigned($random(seed)) % 95));
            tq = '{8'h0D};
            if (k == 1) tq.push_back(8'h0A);
            go({k[0], k[0], 2'b11}, 8'(n), 16'h0A0D, 16'h0, 16'h0, d);
            src.send(bq, 1);
            st(32'h7F, 32'h1);
            src.send(tq, 0);
            wdone;
            st(32'h7F, 32'h2);
            cmem(d, k[0]);
            stop;
        end
        go(4'h3, 8'h03, 16'h000D, 16'h0, 16'h0, 16'h0);
        bq = '{8'h31, 8'h32, 8'h33, 8'h34};
        src.send(bq, 0);
        st(32'h7F, 32'h10);
        bq.delete();
        cmem(16'h0, 1'b0);
        stop;
        $display("Variable done");
        for (k = 0; k < 3; k++) begin
            go(4'h1, 8'h02, 16'h0, 16'(k == 0), (k == 1) ? 16'h2 : 16'h0, 16'h0100);
            bq = '{8'h41};
            if (k != 1) src.send(bq, 0);
            if (k == 1) begin
                // Frozen clock enable must hold the first-character timer
                clk_en <= 1'b0;
                repeat (100) @(posedge pclk);
                clk_en <= 1'b1;
                st(32'h7F, 32'h1);
            end
            repeat (60) @(posedge pclk);
            st(32'h7F, (k == 0) ? 32'h4 : (k == 1) ? 32'h8 : 32'h1);
            bq.delete();
            if (k == 2) begin
                bq = '{8'h41, 8'h42};
                tq = '{8'h42};
                src.send(tq, 0);
                wdone;
            end
            cmem(16'h0100, 1'b0);
            stop;
        end
        $display("Timeouts done");
        go(4'h1, 8'h00, 16'h0, 16'h0, 16'h0, 16'h0);
        st(32'h20, 32'h20);
        stop;
        go(4'h1, 8'h81, 16'h0, 16'h0, 16'h0, 16'h0);
        st(32'h20, 32'h20);
        stop;
        src.ser_active <= 1'b1;
        st(32'h80, 32'h80);
        src.ser_active <= 1'b0;
        st(32'h80, 32'h0);
        src.ser_err <= 1'b1;
        go(4'h1, 8'h02, 16'h0, 16'h0, 16'h0, 16'h0);
        st(32'h140, 32'h140);
        src.ser_err <= 1'b0;
        stop;
        $display("Status done");
        end_of_test;
    end
endmodule
`default_nettype wire
